// ### hdl/ssa_pkg.sv
// Purpose: Shared constants for the safety selection and acknowledgment link
// Assumes: One 20 MHz clock on both ends, plain register port on the device
// Notes: Register offsets are word indices on a 4-bit address

package ssa_pkg;
    // ****************************************************************
    // Widths
    // ****************************************************************
    localparam int SSA_PAIRS = 8;            // Zone module input pairs
    localparam int SSA_SEL_W = 16;           // Selection channels
    localparam int SSA_WORD_W = 16;          // Safe bus control / status word
    localparam int SSA_ADDR_W = 4;           // Register address width
    localparam int SSA_DATA_W = 16;          // Register data width

    // ****************************************************************
    // Register offsets
    // ****************************************************************
    localparam logic [3:0] SSA_REG_PAIR_CFG = 4'h0;   // Bit i set: pair i single-channel
    localparam logic [3:0] SSA_REG_FUNC_MAP = 4'h1;   // Two 4-bit network indices
    localparam logic [3:0] SSA_REG_OUT_SEL = 4'h2;    // Status bit for local pair
    localparam logic [3:0] SSA_REG_BUS_CFG = 4'h3;    // Enable, protocol, mapping
    localparam logic [3:0] SSA_REG_ZONE_CTRL = 4'h4;  // Master, ack, error, door
    localparam logic [3:0] SSA_REG_SEL_STAT = 4'h5;   // Resulting selections
    localparam logic [3:0] SSA_REG_FUNC_NETS = 4'h6;  // Functional networks
    localparam logic [3:0] SSA_REG_BUS_CTRL = 4'h7;   // Last bus control word
    localparam logic [3:0] SSA_REG_IRQ_STAT = 4'h8;   // Sticky events, read only
    localparam logic [3:0] SSA_REG_IRQ_CLR = 4'h9;    // Write one to clear
    localparam logic [3:0] SSA_REG_IRQ_EN = 4'hA;     // Interrupt enables

    // ****************************************************************
    // Field positions
    // ****************************************************************
    localparam int SSA_BUS_EN_BIT = 0;       // Safe bus channel active
    localparam int SSA_BUS_PROTO_LSB = 1;    // Two-bit protocol field
    localparam int SSA_BUS_MAP_LSB = 3;      // Two-bit predefined mapping index
    localparam int SSA_ZONE_MASTER_BIT = 0;  // This axis is zone master
    localparam int SSA_ZONE_ACK_BIT = 1;
    localparam int SSA_ZONE_ERR_BIT = 2;
    localparam int SSA_ZONE_DOOR_BIT = 3;
    localparam int SSA_IRQ_SEL_BIT = 0;      // Selection vector changed
    localparam int SSA_IRQ_BUS_BIT = 1;      // Control word received
    localparam int SSA_IRQ_MISM_BIT = 2;     // Dual-channel pair unequal
    localparam int SSA_IRQ_W = 3;

    // ****************************************************************
    // Codes and reset values
    // ****************************************************************
    localparam logic [1:0] SSA_PROTO_FIXED = 2'h0;   // Protocol of the early firmware level
    localparam logic [1:0] SSA_MAP_DIRECT = 2'h0;    // Bit i to channel i
    localparam logic [1:0] SSA_MAP_SWAP = 2'h1;      // Bytes exchanged
    localparam logic [1:0] SSA_MAP_LOW = 2'h2;       // Low byte only
    localparam logic [15:0] SSA_RST_ZERO = 16'h0000;
endpackage

// ### hdl/ssa_link_if.sv
// Purpose: Discrete pairs and safe bus words between safety master and drive
// Assumes: Both ends on ref_clk; discrete lines are resynchronised on receipt
// Notes: Selection lines low mean selected; a pair acknowledges only when both high

`timescale 1ns/10ps

interface ssa_link_if;
    import ssa_pkg::*;
    logic [SSA_SEL_W-1:0] zone_in;        // Zone module selection inputs
    logic [1:0] func_in;                  // Local functional inputs
    logic [1:0] zone_ack_pair;            // Zone acknowledgment outputs
    logic [1:0] zone_error_pair;          // Zone error outputs
    logic [1:0] door_lock_pair;           // Door locking outputs
    logic [1:0] local_ack_pair;           // Local module output pair
    logic [SSA_WORD_W-1:0] bus_ctrl;      // Safe control word
    logic bus_ctrl_valid;                 // Control word strobe
    logic [SSA_WORD_W-1:0] bus_stat;      // Safe status word

    // Drive end
    modport dev
    (
        input zone_in, func_in, bus_ctrl, bus_ctrl_valid,
        output zone_ack_pair, zone_error_pair, door_lock_pair, local_ack_pair, bus_stat
    );
    // Safety master end
    modport mst
    (
        output zone_in, func_in, bus_ctrl, bus_ctrl_valid,
        input zone_ack_pair, zone_error_pair, door_lock_pair, local_ack_pair, bus_stat
    );
endinterface

// ### hdl/ssa_master.sv
// Purpose: Safety master end: drives selections, judges acknowledgments
// Assumes: Pairs arrive as pins and pass two flip-flops
// Notes: A state counts only with both channels high

`timescale 1ns/10ps

module ssa_master
    import ssa_pkg::*;
(
    input wire logic ref_clk,
    input wire logic nrst,
    ssa_link_if.mst link,
    input wire logic [SSA_SEL_W-1:0] sel_req,      // High requests a selection
    input wire logic [1:0] func_set,               // Functional input levels
    input wire logic [SSA_WORD_W-1:0] ctrl_word,   // Control word to send
    input wire logic ctrl_send,                    // One-cycle send strobe
    output logic zone_ack_ok,                      // Both channels high
    output logic zone_err_ok,
    output logic door_ok,
    output logic local_ok,
    output logic [7:0] diag,                       // Raw channels, diagnosis only
    output logic [SSA_WORD_W-1:0] stat_word        // Last status word
);
    logic [7:0] meta_q;    // First synchroniser stage
    logic [7:0] pin_q;     // Second synchroniser stage
    logic [SSA_SEL_W-1:0] zone_q;
    logic [1:0] func_q;
    logic [SSA_WORD_W-1:0] ctrl_q;
    logic ctrl_v_q;

    // ****************************************************************
    // Outgoing lines
    // ****************************************************************
    // Low drives selection; deselected idles high
    always_ff @(posedge ref_clk or negedge nrst)
        if (!nrst)
        begin
            zone_q <= 16'hFFFF;
            func_q <= 2'h0;
            ctrl_q <= SSA_RST_ZERO;
            ctrl_v_q <= 1'b0;
        end
        else
        begin
            zone_q <= ~sel_req; // RULE3
            func_q <= func_set;
            ctrl_q <= ctrl_send ? ctrl_word : ctrl_q;
            ctrl_v_q <= ctrl_send;
        end

    assign link.zone_in = zone_q;
    assign link.func_in = func_q;
    assign link.bus_ctrl = ctrl_q;
    assign link.bus_ctrl_valid = ctrl_v_q;

    // ****************************************************************
    // Incoming pairs
    // ****************************************************************
    // Two stages before any judgment
    always_ff @(posedge ref_clk or negedge nrst)
        if (!nrst)
        begin
            meta_q <= 8'h00;
            pin_q <= 8'h00;
        end
        else
        begin
            meta_q <= {link.local_ack_pair, link.door_lock_pair, link.zone_error_pair, link.zone_ack_pair};
            pin_q <= meta_q;
        end

    // Both channels evaluated; one channel alone is only diagnosis
    always_ff @(posedge ref_clk or negedge nrst)
        if (!nrst)
        begin
            zone_ack_ok <= 1'b0;
            zone_err_ok <= 1'b0;
            door_ok <= 1'b0;
            local_ok <= 1'b0;
            diag <= 8'h00;
            stat_word <= SSA_RST_ZERO;
        end
        else
        begin
            zone_ack_ok <= &pin_q[1:0]; // RULE8 RULE9
            zone_err_ok <= &pin_q[3:2]; // RULE8 RULE9
            door_ok <= &pin_q[5:4]; // RULE8 RULE9
            local_ok <= &pin_q[7:6]; // RULE11 RULE9
            diag <= pin_q;
            stat_word <= link.bus_stat;
        end
endmodule

// ### hdl/ssa_drive.sv
// Purpose: Drive end: selection inputs, safe bus channel, acknowledgment pairs
// Assumes: Discrete inputs asynchronous; bus words on ref_clk
// Notes: Fail-safe: any low channel of a dual pair selects

`timescale 1ns/10ps

// Function
// RULE1: Each input pair dual or two single
// RULE2: Single mode: each input selects alone
// RULE3: Low input selects, high deselects
// RULE4: Local inputs functional only, never selecting
// RULE5: Two functional inputs routed to networks
// RULE6: Zone pairs driven only by zone master
// RULE7: Three fixed zone pairs, not remappable
// RULE8: Zone acknowledged only with both high
// RULE9: Receiver evaluates both channels of pair
// RULE10: Local pair follows selected status bit
// RULE11: Local safe state only both high
// RULE12: Safe bus channel selects operating states
// RULE13: Discrete and bus selection work together
// RULE14: Bus uses predefined mappings only
// RULE15: One control word in, one status out
// RULE16: Early level forces fixed safety protocol
// RULE17: Later levels need explicit protocol choice; code accepts only field 0, the reset value, with no choice needed
// RULE18: Pairs low after reset until acknowledged
module ssa_drive
    import ssa_pkg::*;
#(
    parameter int EARLY_FW = 1    // 1: protocol fixed on activation
)
(
    input wire logic ref_clk,
    input wire logic nrst,
    ssa_link_if.dev link,
    input wire logic [SSA_ADDR_W-1:0] reg_addr,
    input wire logic [SSA_DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [SSA_DATA_W-1:0] reg_rdata,
    output logic irq
);
    // ****************************************************************
    // Declarations
    // ****************************************************************
    logic [SSA_SEL_W-1:0] zin_meta_q;     // First stage, read by second only
    logic [SSA_SEL_W-1:0] zin_q;          // Synchronised selection inputs
    logic [1:0] fin_meta_q;
    logic [1:0] fin_q;                    // Synchronised functional inputs
    logic [7:0] pair_cfg_q;               // Pair mode per input pair
    logic [7:0] func_map_q;               // Network index per functional input
    logic [3:0] out_sel_q;                // Status bit driving local pair
    logic [4:0] bus_cfg_q;                // Enable, protocol, mapping
    logic [3:0] zone_ctrl_q;              // Master flag and zone states
    logic [SSA_SEL_W-1:0] sel_q;          // Combined selections
    logic [SSA_SEL_W-1:0] disc_sel_d;     // Discrete selections
    logic [SSA_SEL_W-1:0] bus_sel_d;      // Bus selections after mapping
    logic [SSA_SEL_W-1:0] func_nets_d;
    logic [SSA_SEL_W-1:0] func_nets_q;
    logic [SSA_WORD_W-1:0] bus_word_q;    // Last accepted control word
    logic [7:0] mism_d;                   // Dual pairs with unequal channels
    logic [SSA_IRQ_W-1:0] irq_stat_q;
    logic [SSA_IRQ_W-1:0] irq_en_q;
    logic [SSA_IRQ_W-1:0] irq_set_d;
    logic [1:0] proto_d;
    logic bus_on;
    logic [1:0] zone_ack_q;
    logic [1:0] zone_err_q;
    logic [1:0] door_q;
    logic [1:0] local_q;
    logic [SSA_WORD_W-1:0] stat_q;

    initial
    begin
        if (EARLY_FW != 0 && EARLY_FW != 1)
            $error("EARLY_FW must be 0 or 1");
    end

    // ****************************************************************
    // Input synchronisers
    // ****************************************************************
    // Pins are asynchronous; idle level high means deselected
    always_ff @(posedge ref_clk or negedge nrst)
        if (!nrst)
        begin
            zin_meta_q <= 16'hFFFF;
            zin_q <= 16'hFFFF;
            fin_meta_q <= 2'h0;
            fin_q <= 2'h0;
        end
        else
        begin
            zin_meta_q <= link.zone_in;
            zin_q <= zin_meta_q;
            fin_meta_q <= link.func_in;
            fin_q <= fin_meta_q;
        end

    // ****************************************************************
    // Selection evaluation
    // ****************************************************************
    // Dual pair: either low selects both channels, fail-safe choice
    always_comb
    begin
        disc_sel_d = '0;
        mism_d = '0;
        for (int i = 0; i < SSA_PAIRS; i++)
        begin
            if (pair_cfg_q[i]) // RULE1
            begin
                // Single mode: each channel on its own
                disc_sel_d[2*i] = ~zin_q[2*i]; // RULE2 RULE3
                disc_sel_d[2*i+1] = ~zin_q[2*i+1]; // RULE2 RULE3
            end
            else
            begin
                // Dual mode: one safe signal from two inputs
                disc_sel_d[2*i] = ~(zin_q[2*i] & zin_q[2*i+1]); // RULE1 RULE3
                disc_sel_d[2*i+1] = disc_sel_d[2*i];
                mism_d[i] = zin_q[2*i] ^ zin_q[2*i+1];
            end
        end
    end

    // Fixed mapping table; no free bit assignment is offered
    always_comb
    begin
        case (bus_cfg_q[SSA_BUS_MAP_LSB +: 2]) // RULE14
            SSA_MAP_DIRECT: bus_sel_d = bus_word_q;
            SSA_MAP_SWAP: bus_sel_d = {bus_word_q[7:0], bus_word_q[15:8]};
            SSA_MAP_LOW: bus_sel_d = {8'h00, bus_word_q[7:0]};
            default: bus_sel_d = '0;
        endcase
        if (!bus_on)
            bus_sel_d = '0;
    end

    // Early level ignores the protocol field
    assign proto_d = (EARLY_FW == 1) ? SSA_PROTO_FIXED : bus_cfg_q[SSA_BUS_PROTO_LSB +: 2]; // RULE16
    // Later level: channel runs only with protocol field 0, the reset value; codes 1 to 3 keep it off
    assign bus_on = bus_cfg_q[SSA_BUS_EN_BIT] && (proto_d == SSA_PROTO_FIXED); // RULE17

    // Functional inputs only reach networks, never selections
    always_comb
    begin
        func_nets_d = '0;
        func_nets_d[func_map_q[3:0]] = fin_q[0]; // RULE5 RULE4
        func_nets_d[func_map_q[7:4]] = func_nets_d[func_map_q[7:4]] | fin_q[1]; // RULE5
    end

    // Discrete and bus selections combine; either may select
    always_ff @(posedge ref_clk or negedge nrst)
        if (!nrst)
        begin
            sel_q <= '0;
            func_nets_q <= '0;
        end
        else
        begin
            sel_q <= disc_sel_d | bus_sel_d; // RULE13 RULE12 RULE4
            func_nets_q <= func_nets_d;
        end

    // ****************************************************************
    // Safe bus channel
    // ****************************************************************
    // Exactly one control word in, one status word out
    always_ff @(posedge ref_clk or negedge nrst)
        if (!nrst)
        begin
            bus_word_q <= SSA_RST_ZERO;
            stat_q <= SSA_RST_ZERO;
        end
        else
        begin
            if (link.bus_ctrl_valid && bus_on)
                bus_word_q <= link.bus_ctrl; // RULE15 RULE12
            else if (!bus_on)
                bus_word_q <= SSA_RST_ZERO;
            stat_q <= bus_on ? sel_q : SSA_RST_ZERO; // RULE15
        end

    // ****************************************************************
    // Acknowledgment pairs
    // ****************************************************************
    // Fixed roles; only the zone master drives the three zone pairs high, local pair follows sel_q
    always_ff @(posedge ref_clk or negedge nrst)
        if (!nrst)
        begin
            zone_ack_q <= 2'b00; // RULE18
            zone_err_q <= 2'b00; // RULE18
            door_q <= 2'b00; // RULE18
            local_q <= 2'b00; // RULE18
        end
        else
        begin
            zone_ack_q <= {2{zone_ctrl_q[SSA_ZONE_MASTER_BIT] & zone_ctrl_q[SSA_ZONE_ACK_BIT]}}; // RULE6 RULE7 RULE8
            zone_err_q <= {2{zone_ctrl_q[SSA_ZONE_MASTER_BIT] & zone_ctrl_q[SSA_ZONE_ERR_BIT]}}; // RULE6 RULE7 RULE8
            door_q <= {2{zone_ctrl_q[SSA_ZONE_MASTER_BIT] & zone_ctrl_q[SSA_ZONE_DOOR_BIT]}}; // RULE6 RULE7 RULE8
            local_q <= {2{sel_q[out_sel_q]}}; // RULE10 RULE11
        end

    assign link.zone_ack_pair = zone_ack_q;
    assign link.zone_error_pair = zone_err_q;
    assign link.door_lock_pair = door_q;
    assign link.local_ack_pair = local_q;
    assign link.bus_stat = stat_q;

    // ****************************************************************
    // Configuration registers
    // ****************************************************************
    // Written by software; zero after reset
    always_ff @(posedge ref_clk or negedge nrst)
        if (!nrst)
        begin
            pair_cfg_q <= 8'h00;
            func_map_q <= 8'h00;
            out_sel_q <= 4'h0;
            bus_cfg_q <= 5'h00;
            zone_ctrl_q <= 4'h0;
            irq_en_q <= '0;
        end
        else if (reg_wr)
        begin
            case (reg_addr)
                SSA_REG_PAIR_CFG: pair_cfg_q <= reg_wdata[7:0];
                SSA_REG_FUNC_MAP: func_map_q <= reg_wdata[7:0];
                SSA_REG_OUT_SEL: out_sel_q <= reg_wdata[3:0];
                SSA_REG_BUS_CFG: bus_cfg_q <= reg_wdata[4:0];
                SSA_REG_ZONE_CTRL: zone_ctrl_q <= reg_wdata[3:0];
                SSA_REG_IRQ_EN: irq_en_q <= reg_wdata[SSA_IRQ_W-1:0];
                default: ;
            endcase
        end

    // ****************************************************************
    // Events and interrupt
    // ****************************************************************
    assign irq_set_d = {|mism_d, link.bus_ctrl_valid & bus_on, (disc_sel_d | bus_sel_d) != sel_q};

    // Set wins over a clear in the same cycle
    always_ff @(posedge ref_clk or negedge nrst)
        if (!nrst)
            irq_stat_q <= '0;
        else if (reg_wr && reg_addr == SSA_REG_IRQ_CLR)
            irq_stat_q <= (irq_stat_q & ~reg_wdata[SSA_IRQ_W-1:0]) | irq_set_d;
        else
            irq_stat_q <= irq_stat_q | irq_set_d;

    // Level output, registered
    always_ff @(posedge ref_clk or negedge nrst)
        if (!nrst)
            irq <= 1'b0;
        else
            irq <= |(irq_stat_q & irq_en_q);

    // ****************************************************************
    // Read port
    // ****************************************************************
    // Data one cycle after the strobe; unmapped and write-only read zero
    always_ff @(posedge ref_clk or negedge nrst)
        if (!nrst)
            reg_rdata <= '0;
        else if (reg_rd)
        begin
            case (reg_addr)
                SSA_REG_PAIR_CFG: reg_rdata <= {8'h00, pair_cfg_q};
                SSA_REG_FUNC_MAP: reg_rdata <= {8'h00, func_map_q};
                SSA_REG_OUT_SEL: reg_rdata <= {12'h000, out_sel_q};
                SSA_REG_BUS_CFG: reg_rdata <= {11'h000, bus_cfg_q[4:3], proto_d, bus_cfg_q[0]};
                SSA_REG_ZONE_CTRL: reg_rdata <= {12'h000, zone_ctrl_q};
                SSA_REG_SEL_STAT: reg_rdata <= sel_q;
                SSA_REG_FUNC_NETS: reg_rdata <= func_nets_q;
                SSA_REG_BUS_CTRL: reg_rdata <= bus_word_q;
                SSA_REG_IRQ_STAT: reg_rdata <= {13'h0000, irq_stat_q};
                SSA_REG_IRQ_EN: reg_rdata <= {13'h0000, irq_en_q};
                default: reg_rdata <= '0;
            endcase
        end
        else
            reg_rdata <= '0;
endmodule

// ### tb/ssa_link_asserts.sv
// Purpose: Concurrent checks on the link between safety master and drive
// Assumes: Single ref_clk domain, nrst asynchronous active low
// Notes: Sees only the interface signals, instantiated beside the link

`timescale 1ns/10ps

module ssa_link_asserts
    import ssa_pkg::*;
(
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic [SSA_SEL_W-1:0] zone_in,
    input wire logic [1:0] func_in,
    input wire logic [1:0] zone_ack_pair,
    input wire logic [1:0] zone_error_pair,
    input wire logic [1:0] door_lock_pair,
    input wire logic [1:0] local_ack_pair,
    input wire logic [SSA_WORD_W-1:0] bus_ctrl,
    input wire logic bus_ctrl_valid,
    input wire logic [SSA_WORD_W-1:0] bus_stat
);
    // ****************************************************************
    // Clocking and shared sequences
    // ****************************************************************
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!nrst);

    // First edge after reset release
    sequence s_release;
        $rose(nrst);
    endsequence
    // No pair acknowledges anything
    sequence s_all_low;
        zone_ack_pair == 2'h0 && zone_error_pair == 2'h0 && door_lock_pair == 2'h0 && local_ack_pair == 2'h0;
    endsequence

    // ****************************************************************
    // Assertions
    // ****************************************************************
    // No register write can land this early, so pairs must still be low
    chk_pairs_low_reset: assert property (s_release |-> s_all_low [*2])
        else $error("pair high right after reset");
    chk_idle_sel_reset: assert property (s_release |-> zone_in == 16'hFFFF)
        else $error("selection lines not idle high after reset");
    chk_stat_reset_zero: assert property (s_release |-> bus_stat == 16'h0000)
        else $error("status word not clear after reset");
    // A split pair would be a half acknowledgment
    chk_ack_pair_equal: assert property (zone_ack_pair[0] == zone_ack_pair[1])
        else $error("zone ack channels differ");
    chk_err_pair_equal: assert property (zone_error_pair[0] == zone_error_pair[1])
        else $error("zone error channels differ");
    chk_door_pair_equal: assert property (door_lock_pair[0] == door_lock_pair[1])
        else $error("door lock channels differ");
    chk_local_pair_equal: assert property (local_ack_pair[0] == local_ack_pair[1])
        else $error("local channels differ");
    chk_valid_one_cycle: assert property (bus_ctrl_valid |=> !bus_ctrl_valid)
        else $error("control strobe longer than one cycle");
    // Word only changes together with its strobe
    chk_ctrl_word_strobe: assert property ($changed(bus_ctrl) |-> bus_ctrl_valid)
        else $error("control word changed without strobe");
endmodule

// ### tb/tb_safety_select_ack_io.sv
// Purpose: Self-checking bench with master and drive joined by the link
// Assumes: 20 MHz ref_clk, reset held three cycles
// Notes: Settling waits cover the two-flop resync on both ends

`timescale 1ns/10ps

module tb_safety_select_ack_io
    import ssa_pkg::*;
;
    // ****************************************************************
    // Signals
    // ****************************************************************
    logic ref_clk;
    logic nrst;
    logic [3:0] reg_addr;
    logic [15:0] reg_wdata;
    logic reg_wr;
    logic reg_rd;
    logic [15:0] reg_rdata;
    logic irq;
    logic [15:0] sel_req; // High requests a selection
    logic [1:0] func_set;
    logic [15:0] ctrl_word;
    logic ctrl_send;
    logic [3:0] oks; // {ack, err, door, local} as judged by master
    logic [15:0] stat_word;
    logic [7:0] diag; // Raw pair channels
    int n_mismatch;
    int checks_done;
    logic [15:0] bus_w [4];
    logic [15:0] bus_e [4];

    ssa_link_if link();
    ssa_drive ssa_drive_inst (.ref_clk(ref_clk), .nrst(nrst), .link(link), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq));
    ssa_master ssa_master_inst (.ref_clk(ref_clk), .nrst(nrst), .link(link), .sel_req(sel_req),
        .func_set(func_set), .ctrl_word(ctrl_word), .ctrl_send(ctrl_send), .zone_ack_ok(oks[3]),
        .zone_err_ok(oks[2]), .door_ok(oks[1]), .local_ok(oks[0]), .diag(diag), .stat_word(stat_word));
    ssa_link_asserts ssa_link_asserts_inst (.ref_clk(ref_clk), .nrst(nrst), .zone_in(link.zone_in),
        .func_in(link.func_in), .zone_ack_pair(link.zone_ack_pair), .zone_error_pair(link.zone_error_pair),
        .door_lock_pair(link.door_lock_pair), .local_ack_pair(link.local_ack_pair),
        .bus_ctrl(link.bus_ctrl), .bus_ctrl_valid(link.bus_ctrl_valid), .bus_stat(link.bus_stat));

    // ****************************************************************
    // Clock and watchdog
    // ****************************************************************
    initial
    begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end
    // Tests need well under a thousand cycles
    initial
    begin
        repeat (5000) @(posedge ref_clk);
        n_mismatch++;
        wrap_up();
    end

    // ****************************************************************
    // Tasks
    // ****************************************************************
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask
    // Data stand only in the cycle after the strobe
    task automatic rdc(input logic [3:0] a, input logic [15:0] m, input logic [15:0] e);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1 chk(reg_rdata & m, e);
    endtask
    // Covers resync on both ends plus the ack path
    task automatic settle();
        repeat (10) @(posedge ref_clk);
        #1;
    endtask
    task automatic send(input logic [15:0] w);
        @(posedge ref_clk);
        ctrl_word <= w;
        ctrl_send <= 1'b1;
        @(posedge ref_clk);
        ctrl_send <= 1'b0;
        settle();
    endtask
    task automatic wrap_up();
        $display("checks=%0d mismatches=%0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial
    begin
        nrst = 1'b0;
        {reg_addr, reg_wdata, reg_wr, reg_rd, sel_req, func_set, ctrl_word, ctrl_send} = '0;
        bus_w = '{16'h12F0, 16'h12F0, 16'h12F0, 16'h12F0};
        bus_e = '{16'h12F0, 16'hF012, 16'h00F0, 16'h0000};
        repeat (3) @(posedge ref_clk);
        nrst <= 1'b1;
        settle();
        chk({12'h000, oks}, 16'h0000);
        rdc(SSA_REG_IRQ_STAT, 16'hFFFF, 16'h0000);
        // Acknowledge bits without mastership stay dark
        wr(SSA_REG_ZONE_CTRL, 16'h000E);
        settle();
        chk({12'h000, oks}, 16'h0000);
        wr(SSA_REG_ZONE_CTRL, 16'h000F);
        settle();
        chk({12'h000, oks}, 16'h000E);
        wr(SSA_REG_ZONE_CTRL, 16'h000D);
        settle();
        chk({12'h000, oks}, 16'h0006);
        chk({8'h00, diag}, 16'h003C);
        // Dual pair: one low line selects both channels
        @(posedge ref_clk) sel_req <= 16'h0001;
        settle();
        rdc(SSA_REG_SEL_STAT, 16'hFFFF, 16'h0003);
        chk({12'h000, oks}, 16'h0007);
        rdc(SSA_REG_IRQ_STAT, 16'h0004, 16'h0004);
        wr(SSA_REG_PAIR_CFG, 16'h0001);
        settle();
        rdc(SSA_REG_SEL_STAT, 16'hFFFF, 16'h0001);
        wr(SSA_REG_OUT_SEL, 16'h0001);
        settle();
        chk({12'h000, oks}, 16'h0006);
        // Functional inputs reach networks, never selections
        @(posedge ref_clk) sel_req <= 16'h0000;
        func_set <= 2'h3;
        wr(SSA_REG_FUNC_MAP, 16'h0052);
        settle();
        rdc(SSA_REG_FUNC_NETS, 16'hFFFF, 16'h0024);
        rdc(SSA_REG_SEL_STAT, 16'hFFFF, 16'h0000);
        // Every predefined mapping once
        for (int m = 0; m < 4; m++)
        begin
            wr(SSA_REG_BUS_CFG, 16'h0001 | 16'(m << 3));
            send(bus_w[m]);
            rdc(SSA_REG_SEL_STAT, 16'hFFFF, bus_e[m]);
        end
        chk(stat_word, 16'h0000);
        // Bus and discrete selection side by side
        wr(SSA_REG_BUS_CFG, 16'h0007);
        rdc(SSA_REG_BUS_CFG, 16'h0007, 16'h0001);
        @(posedge ref_clk) sel_req <= 16'h8000;
        send(16'h0011);
        rdc(SSA_REG_BUS_CTRL, 16'hFFFF, 16'h0011);
        rdc(SSA_REG_SEL_STAT, 16'hFFFF, 16'hC011);
        chk(stat_word, 16'hC011);
        // Interrupt: masked, enabled, cleared
        @(posedge ref_clk) sel_req <= 16'h0000;
        settle();
        chk({15'h0000, irq}, 16'h0000);
        wr(SSA_REG_IRQ_EN, 16'h0002);
        settle();
        chk({15'h0000, irq}, 16'h0001);
        wr(SSA_REG_IRQ_CLR, 16'h0007);
        wr(SSA_REG_IRQ_STAT, 16'h0007);
        settle();
        chk({15'h0000, irq}, 16'h0000);
        rdc(SSA_REG_IRQ_STAT, 16'hFFFF, 16'h0000);
        rdc(SSA_REG_IRQ_CLR, 16'hFFFF, 16'h0000);
        rdc(4'hF, 16'hFFFF, 16'h0000);
        wrap_up();
    end
endmodule
